/* dv/t0ccr_assertions.sv */
// concurrent checks on the timer0 control and compare ports
`timescale 1ns/1ps
module t0ccr_assertions
    import t0ccr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  t0ccr_bus_req_t  cpu_req,
    input  wire logic [7:0] cpu_rdata,
    input  wire logic       global_irq_enable,
    input  wire logic       async_timer_mode,
    input  wire logic       async_reset_done,
    input  wire logic [2:0] irq_request,
    input  wire logic       waveform_a_connected,
    input  wire logic       shared_prescaler_reset,
    input  wire logic       async_prescaler_reset
);
    logic wr_d, rd_d, sync_wr;
    assign wr_d = cpu_req.wr && !cpu_req.io_space;
    assign rd_d = cpu_req.rd && !cpu_req.io_space;
    assign sync_wr = wr_d && cpu_req.addr == T0CCR_OFS_SYNC_CTRL;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_irq_global: assert property (!$past(global_irq_enable)
        |-> irq_request == 3'h0) else $error("irq without global enable");
    a_force_zero: assert property (rd_d
        && cpu_req.addr == T0CCR_OFS_CTRL_B |=> cpu_rdata[7:6] == 2'b00)
        else $error("force bits read nonzero");
    a_io_unmapped: assert property (cpu_req.rd && cpu_req.io_space
        && cpu_req.addr > T0CCR_IO_LIMIT |=> cpu_rdata == 8'h00)
        else $error("unmapped io read nonzero");
    a_rdata_stands: assert property (!cpu_req.rd
        |=> $stable(cpu_rdata)) else $error("read data moved without read");
    a_sync_pulse: assert property (sync_wr && cpu_req.wdata[0]
        && !cpu_req.wdata[7] |=> shared_prescaler_reset ##1
        !shared_prescaler_reset) else $error("shared reset not one cycle");
    a_tsm_clear: assert property (sync_wr
        && cpu_req.wdata == 8'h00 |=> !shared_prescaler_reset
        && !async_prescaler_reset) else $error("resets not cleared");
    a_async_hold: assert property (async_prescaler_reset
        && async_timer_mode && !async_reset_done && !cpu_req.wr
        |=> async_prescaler_reset) else $error("async reset dropped early");
    a_conn_follow: assert property (wr_d
        && cpu_req.addr == T0CCR_OFS_CTRL_A |=> waveform_a_connected
        == $past(|cpu_req.wdata[7:6])) else $error("connect wrong");
endmodule : t0ccr_assertions

bind t0ccr_top t0ccr_assertions u_chk (.mclk, .rst, .cpu_req, .cpu_rdata,
    .global_irq_enable, .async_timer_mode, .async_reset_done,
    .irq_request, .waveform_a_connected, .shared_prescaler_reset,
    .async_prescaler_reset);

/* dv/t0ccr_pin_model.sv */
// count pin source: bursts of four pulses, idle high between bursts
`timescale 1ns/1ps
module t0ccr_pin_model (
    input  wire logic mclk,
    input  wire logic go,
    output logic      pin
);
    logic [6:0] cnt;
    initial begin
        pin = 1'b1;
        cnt = 7'h00;
    end
    // eight cycles a level, well beyond the synchroniser depth
    always @(posedge mclk) begin
        if (go)
            cnt <= 7'h40;
        else if (|cnt)
            cnt <= cnt - 7'h01;
        if (|cnt && cnt[2:0] == 3'h0)
            pin <= ~pin;
    end
endmodule : t0ccr_pin_model

/* dv/tb_timer0_control_compare_regs.sv */
// self-checking bench for the timer0 control and compare block
`timescale 1ns/1ps
module tb_timer0_control_compare_regs;
    import t0ccr_pkg::*;
    logic           mclk, rst, pin, go, gie, amode, adone;
    logic           wa, wb, ca, cb, spr, apr;
    logic [2:0]     vack, irq;
    logic [7:0]     rdata, rdv, c0;
    t0ccr_bus_req_t req;
    int             n_mismatch, compares;

    t0ccr_top DUT (.mclk(mclk), .rst(rst), .cpu_req(req), .cpu_rdata(rdata),
        .external_count_pin(pin), .global_irq_enable(gie), .vector_ack(vack),
        .async_timer_mode(amode), .async_reset_done(adone), .irq_request(irq),
        .waveform_out_a(wa), .waveform_out_b(wb), .waveform_a_connected(ca),
        .waveform_b_connected(cb), .shared_prescaler_reset(spr),
        .async_prescaler_reset(apr));
    t0ccr_pin_model u_pin (.mclk(mclk), .go(go), .pin(pin));

    always #20 mclk = ~mclk;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    // one access; read data sampled once it has settled
    task automatic bus(input logic io, input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(negedge mclk);
        req = '{addr: a, io_space: io, wr: w, rd: !w, wdata: d};
        @(negedge mclk);
        req = '0;
        @(negedge mclk);
        rdv = rdata;
    endtask : bus

    task automatic t_regs;
        logic [7:0] ofs [6] = '{8'h43, 8'h45, 8'h46, 8'h47, 8'h48, 8'h6e};
        foreach (ofs[i]) begin
            bus(0, ofs[i], 0, 0);
            chk8(rdv, 8'h00);
        end
        bus(0, 8'h47, 1, 8'ha5);
        bus(1, 8'h27, 0, 0);
        chk8(rdv, 8'ha5);
        bus(1, 8'h66, 1, 8'hff);
        bus(1, 8'h66, 0, 0);
        chk8(rdv, 8'h00);
        bus(0, 8'h6e, 1, 8'h07);
        bus(0, 8'h6e, 0, 0);
        chk8(rdv, 8'h07);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_force;
        logic [7:0] mode [4] = '{8'hc0, 8'h80, 8'h40, 8'h40};
        logic [7:0] exp  [4] = '{8'h01, 8'h00, 8'h01, 8'h00};
        foreach (mode[i]) begin
            bus(0, 8'h44, 1, mode[i]);
            bus(0, 8'h45, 1, 8'h80);
            chk8({7'h0, wa}, exp[i]);
        end
        bus(0, 8'h45, 0, 0);
        chk8(rdv, 8'h00);
        bus(0, 8'h44, 1, 8'hc3);
        bus(0, 8'h45, 1, 8'h80);
        chk8({7'h0, wa}, 8'h00);
        bus(0, 8'h45, 1, 8'h00);
        bus(0, 8'h44, 1, 8'h30);
        chk8({7'h0, cb}, 8'h01);
        bus(0, 8'h45, 1, 8'h40);
        chk8({7'h0, wb}, 8'h01);
        bus(0, 8'h35, 0, 0);
        chk8(rdv, 8'h00);
        $display("t_force done");
    endtask : t_force

    // for the first six codes reads spaced exactly n cycles apart, pin codes read after a burst; a back-to-back pair is 3 apart
    task automatic t_count;
        int n [8] = '{16, 3, 24, 192, 768, 3072, 0, 0};
        for (int i = 0; i < 8; i++) begin
            bus(0, 8'h45, 1, i[7:0]);
            bus(0, 8'h46, 0, 0);
            c0 = rdv;
            if (i > 5) begin
                go = 1;
                @(negedge mclk);
                go = 0;
                repeat (80) @(negedge mclk);
            end else begin
                repeat (n[i] - 3) @(negedge mclk);
            end
            bus(0, 8'h46, 0, 0);
            chk8(rdv - c0, (i == 0) ? 8'h00 : 8'(3 + (i > 5)));
        end
        $display("t_count done");
    endtask : t_count

    task automatic t_sync;
        bus(0, 8'h45, 1, 8'h02);
        bus(0, 8'h43, 1, 8'h01);
        bus(0, 8'h43, 0, 0);
        chk8(rdv, 8'h00);
        bus(0, 8'h43, 1, 8'h83);
        bus(0, 8'h43, 0, 0);
        chk8(rdv, 8'h83);
        bus(0, 8'h46, 0, 0);
        c0 = rdv;
        repeat (20) @(negedge mclk);
        bus(0, 8'h46, 0, 0);
        chk8(rdv, c0);
        bus(0, 8'h43, 1, 8'h00);
        bus(0, 8'h43, 0, 0);
        chk8(rdv, 8'h00);
        amode = 1;
        bus(0, 8'h43, 1, 8'h02);
        bus(0, 8'h43, 0, 0);
        chk8(rdv, 8'h02);
        adone = 1;
        @(negedge mclk);
        adone = 0;
        bus(0, 8'h43, 0, 0);
        chk8(rdv, 8'h00);
        amode = 0;
        $display("t_sync done");
    endtask : t_sync

    task automatic t_match;
        logic [7:0] start [2] = '{8'h05, 8'h04};
        bus(0, 8'h6e, 1, 8'h02);
        gie = 1;
        foreach (start[i]) begin
            bus(0, 8'h45, 1, 8'h00);
            bus(0, 8'h47, 1, 8'h05);
            bus(0, 8'h35, 1, 8'h07);
            bus(0, 8'h46, 1, start[i]);
            bus(0, 8'h45, 1, 8'h01);
            bus(0, 8'h45, 1, 8'h00);
            bus(0, 8'h35, 0, 0);
            chk8(rdv & 8'h02, {6'h0, i[0], 1'b0});
        end
        chk8({5'h0, irq}, 8'h02);
        gie = 0;
        repeat (2) @(negedge mclk);
        chk8({5'h0, irq}, 8'h00);
        gie = 1;
        vack = 3'h2;
        @(negedge mclk);
        vack = 3'h0;
        repeat (2) @(negedge mclk);
        chk8({5'h0, irq}, 8'h00);
        $display("t_match done");
    endtask : t_match

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        {mclk, rst, go, gie, amode, adone, vack, req} = '0;
        rst = 1;
        repeat (16) @(negedge mclk);
        rst = 0;
        t_regs;
        t_force;
        t_count;
        t_sync;
        t_match;
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        print_verdict;
    end
endmodule : tb_timer0_control_compare_regs

/* pkg/t0ccr_pkg.sv */
// shared constants and carrier types for the timer0 control/compare block
package t0ccr_pkg;

    // data-space offsets; the short i/o address is the offset less 0x20
    localparam logic [7:0] T0CCR_IO_BIAS        = 8'h20;
    localparam logic [7:0] T0CCR_IO_LIMIT       = 8'h3f;
    localparam logic [7:0] T0CCR_OFS_FLAGS      = 8'h35;
    localparam logic [7:0] T0CCR_OFS_SYNC_CTRL  = 8'h43;
    localparam logic [7:0] T0CCR_OFS_CTRL_A     = 8'h44;
    localparam logic [7:0] T0CCR_OFS_CTRL_B     = 8'h45;
    localparam logic [7:0] T0CCR_OFS_COUNT      = 8'h46;
    localparam logic [7:0] T0CCR_OFS_CMP_A      = 8'h47;
    localparam logic [7:0] T0CCR_OFS_CMP_B      = 8'h48;
    localparam logic [7:0] T0CCR_OFS_IRQ_MASK   = 8'h6e;

    localparam logic [7:0] T0CCR_RST_BYTE       = 8'h00;
    localparam logic [7:0] T0CCR_MAX            = 8'hff;
    localparam logic [7:0] T0CCR_BOTTOM         = 8'h00;

    // control register b
    localparam int T0CCR_FORCE_A_BIT    = 7;
    localparam int T0CCR_FORCE_B_BIT    = 6;
    localparam int T0CCR_WGM2_BIT       = 3;
    localparam int T0CCR_CS_LSB         = 0;
    // control register a
    localparam int T0CCR_COM_A_LSB      = 6;
    localparam int T0CCR_COM_B_LSB      = 4;
    localparam int T0CCR_WGM_LO_LSB     = 0;
    // sync/prescaler control
    localparam int T0CCR_HOLD_BIT       = 7;
    localparam int T0CCR_PSR_ASYNC_BIT  = 1;
    localparam int T0CCR_PSR_SYNC_BIT   = 0;
    // irq enable mask and flag register share one layout
    localparam int T0CCR_CMP_B_BIT      = 2;
    localparam int T0CCR_CMP_A_BIT      = 1;
    localparam int T0CCR_OVF_BIT        = 0;

    // clock select codes
    localparam logic [2:0] T0CCR_CS_STOP    = 3'h0;
    localparam logic [2:0] T0CCR_CS_DIV1    = 3'h1;
    localparam logic [2:0] T0CCR_CS_DIV8    = 3'h2;
    localparam logic [2:0] T0CCR_CS_DIV64   = 3'h3;
    localparam logic [2:0] T0CCR_CS_DIV256  = 3'h4;
    localparam logic [2:0] T0CCR_CS_DIV1024 = 3'h5;
    localparam logic [2:0] T0CCR_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] T0CCR_CS_EXT_RISE = 3'h7;

    // waveform mode codes {waveform_mode_bit2, low bits}
    localparam logic [2:0] T0CCR_WGM_NORMAL   = 3'h0;
    localparam logic [2:0] T0CCR_WGM_PC_FF    = 3'h1;
    localparam logic [2:0] T0CCR_WGM_CLR_CMP  = 3'h2;
    localparam logic [2:0] T0CCR_WGM_FAST_FF  = 3'h3;
    localparam logic [2:0] T0CCR_WGM_PC_OCRA  = 3'h5;
    localparam logic [2:0] T0CCR_WGM_FAST_OCRA = 3'h7;

    localparam int T0CCR_PRESC_W = 10;

    typedef struct packed {
        logic [7:0] addr;
        logic       io_space;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } t0ccr_bus_req_t;

    // one-cycle prescaler taps, index 0 is undivided
    typedef struct packed {
        logic div1024;
        logic div256;
        logic div64;
        logic div8;
        logic div1;
    } t0ccr_taps_t;

endpackage : t0ccr_pkg

/* src/t0ccr_pin_sync.sv */
// three-stage synchroniser and edge detector for the external count pin
`timescale 1ns/1ps
module t0ccr_pin_sync (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       s3;
        logic       lvl;
        logic [1:0] fill;
    } t0ccr_sync_state_t;

    t0ccr_sync_state_t state_reg;
    t0ccr_sync_state_t state_next;

    always_comb begin
        state_next    = state_reg;
        state_next.s1 = pin_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        // settle the accepted level first; avoids a false edge after reset
        if (!(&state_reg.fill)) begin
            state_next.fill = 2'(state_reg.fill + 1'b1);
            state_next.lvl  = state_reg.s2;
        end else if (state_reg.s2 == state_reg.s3) begin
            state_next.lvl = state_reg.s3;
        end
    end

    // a change counts once s2 and s3 agree; s1 may be metastable
    always_comb begin
        rise = (&state_reg.fill) && state_reg.s2 && state_reg.s3
               && !state_reg.lvl;
        fall = (&state_reg.fill) && !state_reg.s2 && !state_reg.s3
               && state_reg.lvl;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : t0ccr_pin_sync

/* src/t0ccr_prescaler.sv */
// shared ten-bit prescaler producing one-cycle division taps
`timescale 1ns/1ps
module t0ccr_prescaler
    import t0ccr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        presc_clear,
    output t0ccr_taps_t      taps
);
    typedef struct packed {
        logic [T0CCR_PRESC_W-1:0] cnt;
    } t0ccr_presc_state_t;

    t0ccr_presc_state_t state_reg;
    t0ccr_presc_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (presc_clear) begin
            state_next.cnt = '0;
        end else begin
            state_next.cnt = state_reg.cnt + 1'b1;
        end
    end

    // taps fire on the last phase of each division period
    always_comb begin
        taps.div1    = !presc_clear;
        taps.div8    = !presc_clear && (&state_reg.cnt[2:0]);
        taps.div64   = !presc_clear && (&state_reg.cnt[5:0]);
        taps.div256  = !presc_clear && (&state_reg.cnt[7:0]);
        taps.div1024 = !presc_clear && (&state_reg.cnt[9:0]);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : t0ccr_prescaler

/* src/t0ccr_top.sv */
// 8-bit timer0 with control, compare, mask and prescaler sync registers
`timescale 1ns/1ps
module t0ccr_top
    import t0ccr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  t0ccr_bus_req_t   cpu_req,
    output logic [7:0]       cpu_rdata,
    input  wire logic        external_count_pin,
    input  wire logic        global_irq_enable,
    input  wire logic [2:0]  vector_ack,
    input  wire logic        async_timer_mode,
    input  wire logic        async_reset_done,
    output logic [2:0]       irq_request,
    output logic             waveform_out_a,
    output logic             waveform_out_b,
    output logic             waveform_a_connected,
    output logic             waveform_b_connected,
    output logic             shared_prescaler_reset,
    output logic             async_prescaler_reset
);
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [1:0] wgm_lo;
        logic       wgm2;
        logic [2:0] cs;
        logic [2:0] irq_en;
        logic [2:0] flags;
        logic       hold;
        logic       psr_async;
        logic       psr_sync;
        logic       shared_rst;
        logic       async_rst;
        logic       down;
        logic       block;
        logic       wave_a;
        logic       wave_b;
        logic [1:0] conn;
        logic [7:0] rdata;
        logic [2:0] irq;
    } t0ccr_state_t;

    t0ccr_state_t state_reg;
    t0ccr_state_t state_next;
    t0ccr_taps_t  taps;
    logic         pin_rise;
    logic         pin_fall;

    t0ccr_prescaler u_prescaler (
        .mclk        (mclk),
        .rst         (rst),
        .presc_clear (state_reg.shared_rst),
        .taps        (taps)
    );

    t0ccr_pin_sync u_pin_sync (
        .mclk   (mclk),
        .rst    (rst),
        .pin_in (external_count_pin),
        .rise   (pin_rise),
        .fall   (pin_fall)
    );

    // map a short i/o address into data space
    function automatic logic [7:0] t0ccr_norm_addr(
        input logic [7:0] addr,
        input logic       io_space
    );
        if (io_space && addr <= T0CCR_IO_LIMIT) begin
            return 8'(addr + T0CCR_IO_BIAS);
        end
        return io_space ? 8'hff : addr;
    endfunction : t0ccr_norm_addr

    // compare action: toggle, drive dir, drive inverse dir
    function automatic logic t0ccr_wave(
        input logic       cur,
        input logic [1:0] com,
        input logic       dir
    );
        unique case (com)
            2'h0: return cur;
            2'h1: return !cur;
            2'h2: return dir;
            2'h3: return !dir;
        endcase
    endfunction : t0ccr_wave

    // in pwm modes toggle is only legal on channel a with wgm2
    function automatic logic [1:0] t0ccr_pwm_com(
        input logic [1:0] com,
        input logic       toggle_ok
    );
        return (com == 2'h1 && !toggle_ok) ? 2'h0 : com;
    endfunction : t0ccr_pwm_com

    logic [2:0] wgm;
    logic       is_pc;
    logic       is_fast;
    logic       non_pwm;
    logic [7:0] top;
    logic       tick;
    logic [7:0] addr_n;
    logic       wr;
    logic       match_a;
    logic       match_b;
    logic       ovf;
    logic [1:0] eff_com_a;
    logic [1:0] eff_com_b;
    logic [7:0] rd_val;
    logic       hold_new;

    always_comb begin
        wgm     = {state_reg.wgm2, state_reg.wgm_lo};
        is_pc   = (wgm == T0CCR_WGM_PC_FF) || (wgm == T0CCR_WGM_PC_OCRA);
        is_fast = (wgm == T0CCR_WGM_FAST_FF) || (wgm == T0CCR_WGM_FAST_OCRA);
        // reserved codes run as normal counting
        non_pwm = !is_pc && !is_fast;
        top     = (wgm == T0CCR_WGM_CLR_CMP || wgm == T0CCR_WGM_PC_OCRA ||
                   wgm == T0CCR_WGM_FAST_OCRA) ? state_reg.cmp_a : T0CCR_MAX;
        addr_n  = t0ccr_norm_addr(cpu_req.addr, cpu_req.io_space);
        wr      = cpu_req.wr;
        eff_com_a = t0ccr_pwm_com(state_reg.com_a, state_reg.wgm2);
        eff_com_b = t0ccr_pwm_com(state_reg.com_b, 1'b0);
    end

    always_comb begin
        unique case (state_reg.cs)
            T0CCR_CS_STOP:     tick = 1'b0;
            T0CCR_CS_DIV1:     tick = taps.div1;
            T0CCR_CS_DIV8:     tick = taps.div8;
            T0CCR_CS_DIV64:    tick = taps.div64;
            T0CCR_CS_DIV256:   tick = taps.div256;
            T0CCR_CS_DIV1024:  tick = taps.div1024;
            T0CCR_CS_EXT_FALL: tick = pin_fall;
            T0CCR_CS_EXT_RISE: tick = pin_rise;
        endcase
    end

    // continuous compare, sampled on the timer tick
    always_comb begin
        match_a = tick && !state_reg.block &&
                  (state_reg.count == state_reg.cmp_a);
        match_b = tick && !state_reg.block &&
                  (state_reg.count == state_reg.cmp_b);
        if (is_pc) begin
            ovf = tick && state_reg.down && (state_reg.count == T0CCR_BOTTOM);
        end else if (wgm == T0CCR_WGM_FAST_OCRA) begin
            ovf = tick && (state_reg.count == top);
        end else begin
            ovf = tick && (state_reg.count == T0CCR_MAX);
        end
    end

    always_comb begin
        rd_val = T0CCR_RST_BYTE;
        unique case (addr_n)
            T0CCR_OFS_FLAGS:     rd_val = {5'h0, state_reg.flags};
            T0CCR_OFS_SYNC_CTRL: rd_val = {state_reg.hold, 5'h0,
                                           state_reg.psr_async,
                                           state_reg.psr_sync};
            T0CCR_OFS_CTRL_A:    rd_val = {state_reg.com_a, state_reg.com_b,
                                           2'h0, state_reg.wgm_lo};
            T0CCR_OFS_CTRL_B:    rd_val = {2'h0, 2'h0, state_reg.wgm2,
                                           state_reg.cs};
            T0CCR_OFS_COUNT:     rd_val = state_reg.count;
            T0CCR_OFS_CMP_A:     rd_val = state_reg.cmp_a;
            T0CCR_OFS_CMP_B:     rd_val = state_reg.cmp_b;
            T0CCR_OFS_IRQ_MASK:  rd_val = {5'h0, state_reg.irq_en};
            default:             rd_val = T0CCR_RST_BYTE;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        hold_new   = state_reg.hold;
        if (cpu_req.rd) begin
            state_next.rdata = rd_val;
        end

        if (tick) begin
            state_next.block = 1'b0;
            if (is_pc) begin
                if (!state_reg.down) begin
                    if (state_reg.count == top) begin
                        state_next.down  = 1'b1;
                        state_next.count = 8'(state_reg.count - 1'b1);
                    end else begin
                        state_next.count = 8'(state_reg.count + 1'b1);
                    end
                end else if (state_reg.count == T0CCR_BOTTOM) begin
                    state_next.down  = 1'b0;
                    state_next.count = 8'(state_reg.count + 1'b1);
                end else begin
                    state_next.count = 8'(state_reg.count - 1'b1);
                end
                if (match_a) begin
                    state_next.wave_a = t0ccr_wave(state_reg.wave_a,
                                                   eff_com_a, state_reg.down);
                end
                if (match_b) begin
                    state_next.wave_b = t0ccr_wave(state_reg.wave_b,
                                                   eff_com_b, state_reg.down);
                end
            end else begin
                if (state_reg.count == top) begin
                    state_next.count = T0CCR_BOTTOM;
                end else begin
                    state_next.count = 8'(state_reg.count + 1'b1);
                end
                if (is_fast) begin
                    // a match at top is dropped when set/clear is selected
                    if (match_a && !(state_reg.cmp_a == top &&
                                     state_reg.com_a[1])) begin
                        state_next.wave_a = t0ccr_wave(state_reg.wave_a,
                                                       eff_com_a, 1'b0);
                    end
                    if (match_b && !(state_reg.cmp_b == top &&
                                     state_reg.com_b[1])) begin
                        state_next.wave_b = t0ccr_wave(state_reg.wave_b,
                                                       eff_com_b, 1'b0);
                    end
                    if (state_reg.count == top && state_reg.com_a[1]) begin
                        state_next.wave_a = !state_reg.com_a[0];
                    end
                    if (state_reg.count == top && state_reg.com_b[1]) begin
                        state_next.wave_b = !state_reg.com_b[0];
                    end
                end else begin
                    if (match_a) begin
                        state_next.wave_a = t0ccr_wave(state_reg.wave_a,
                                                       state_reg.com_a, 1'b0);
                    end
                    if (match_b) begin
                        state_next.wave_b = t0ccr_wave(state_reg.wave_b,
                                                       state_reg.com_b, 1'b0);
                    end
                end
            end
        end

        // event flags: set beats any clear in the same cycle
        if (wr && addr_n == T0CCR_OFS_FLAGS) begin
            state_next.flags = state_reg.flags & ~cpu_req.wdata[2:0];
        end
        state_next.flags = state_next.flags & ~vector_ack;
        state_next.flags[T0CCR_CMP_A_BIT] = state_next.flags[T0CCR_CMP_A_BIT]
                                            | match_a;
        state_next.flags[T0CCR_CMP_B_BIT] = state_next.flags[T0CCR_CMP_B_BIT]
                                            | match_b;
        state_next.flags[T0CCR_OVF_BIT]   = state_next.flags[T0CCR_OVF_BIT]
                                            | ovf;

        // software writes
        if (wr) begin
            unique case (addr_n)
                T0CCR_OFS_CTRL_A: begin
                    state_next.com_a  = cpu_req.wdata[T0CCR_COM_A_LSB +: 2];
                    state_next.com_b  = cpu_req.wdata[T0CCR_COM_B_LSB +: 2];
                    state_next.wgm_lo = cpu_req.wdata[T0CCR_WGM_LO_LSB +: 2];
                end
                T0CCR_OFS_CTRL_B: begin
                    state_next.wgm2 = cpu_req.wdata[T0CCR_WGM2_BIT];
                    state_next.cs   = cpu_req.wdata[T0CCR_CS_LSB +: 3];
                    // forced match moves the pin only; no flag, no clear
                    if (non_pwm && cpu_req.wdata[T0CCR_FORCE_A_BIT]) begin
                        state_next.wave_a = t0ccr_wave(state_next.wave_a,
                            state_reg.com_a, 1'b0);
                    end
                    if (non_pwm && cpu_req.wdata[T0CCR_FORCE_B_BIT]) begin
                        state_next.wave_b = t0ccr_wave(state_next.wave_b,
                            state_reg.com_b, 1'b0);
                    end
                end
                T0CCR_OFS_COUNT: begin
                    // software write wins over the tick's increment
                    state_next.count = cpu_req.wdata;
                    state_next.block = 1'b1;
                end
                T0CCR_OFS_CMP_A:    state_next.cmp_a = cpu_req.wdata;
                T0CCR_OFS_CMP_B:    state_next.cmp_b = cpu_req.wdata;
                T0CCR_OFS_IRQ_MASK:
                    state_next.irq_en = cpu_req.wdata[2:0];
                T0CCR_OFS_SYNC_CTRL: hold_new = cpu_req.wdata[T0CCR_HOLD_BIT];
                default: ;
            endcase
        end
        state_next.hold = hold_new;
        state_next.conn = {|state_next.com_b, |state_next.com_a};

        // prescaler reset bits
        if (wr && addr_n == T0CCR_OFS_SYNC_CTRL) begin
            // sync bit held only while sync mode stays on; async bit also while async_timer_mode is set
            state_next.psr_sync  = cpu_req.wdata[T0CCR_PSR_SYNC_BIT]
                                   & hold_new;
            state_next.psr_async = cpu_req.wdata[T0CCR_PSR_ASYNC_BIT]
                & (hold_new | async_timer_mode);
        end else if (!state_reg.hold) begin
            state_next.psr_sync = 1'b0;
            if (!async_timer_mode || async_reset_done) begin
                state_next.psr_async = 1'b0;
            end
        end
        if (state_reg.hold && !hold_new) begin
            state_next.psr_sync  = 1'b0;
            state_next.psr_async = 1'b0;
        end
        state_next.shared_rst = state_next.psr_sync
            | (wr && addr_n == T0CCR_OFS_SYNC_CTRL
               && cpu_req.wdata[T0CCR_PSR_SYNC_BIT]);
        state_next.async_rst = state_next.psr_async
            | (wr && addr_n == T0CCR_OFS_SYNC_CTRL
               && cpu_req.wdata[T0CCR_PSR_ASYNC_BIT]);

        state_next.irq = state_next.flags & state_next.irq_en
                         & {3{global_irq_enable}};
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        cpu_rdata              = state_reg.rdata;
        irq_request            = state_reg.irq;
        waveform_out_a         = state_reg.wave_a;
        waveform_out_b         = state_reg.wave_b;
        waveform_a_connected   = state_reg.conn[0];
        waveform_b_connected   = state_reg.conn[1];
        shared_prescaler_reset = state_reg.shared_rst;
        async_prescaler_reset  = state_reg.async_rst;
    end

endmodule : t0ccr_top
